// ===== design/accel_data_status_regs.sv
// data and status register bank: samples, buffer count, condition flags, soft restart
// assumes register strobes and event pulses arrive synchronous to core_clk_i
`timescale 1ns/1ps
module accel_data_status_regs (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // register port from the serial front end
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [accel_regs_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [accel_regs_pkg::DATA_W-1:0] reg_wdata_i,
    output logic [accel_regs_pkg::DATA_W-1:0] reg_rdata_o,
    // samples from the measurement path
    input wire logic sample_valid_i,
    input wire logic [accel_regs_pkg::SAMPLE_W-1:0] x_sample_i,
    input wire logic [accel_regs_pkg::SAMPLE_W-1:0] y_sample_i,
    input wire logic [accel_regs_pkg::SAMPLE_W-1:0] z_sample_i,
    input wire logic [accel_regs_pkg::SAMPLE_W-1:0] thermal_sample_i,
    // sample buffer
    input wire logic [accel_regs_pkg::COUNT_W-1:0] buffer_count_i,
    input wire logic [accel_regs_pkg::MARK_W-1:0] buffer_mark_i,
    input wire logic buffer_overrun_i,
    input wire logic buffer_read_i,
    // detectors and configuration
    input wire logic motion_event_i,
    input wire logic stillness_event_i,
    input wire logic [1:0] motion_detect_control_i,
    input wire logic single_event_upset_i,
    // control outputs
    output logic soft_reset_o,
    output logic int_hiz_o,
    output logic motion_armed_o,
    output logic stillness_armed_o
);
    import accel_regs_pkg::*;

    typedef struct packed {
        logic [SAMPLE_W-1:0] x;
        logic [SAMPLE_W-1:0] y;
        logic [SAMPLE_W-1:0] z;
        logic [SAMPLE_W-1:0] t;
        logic [COUNT_W-1:0] count;
        logic err;
        logic awake;
        logic still;
        logic motion;
        logic overrun;
        logic mark;
        logic ready;
        logic data_ready;
        logic [DATA_W-1:0] rdata;
        logic soft_reset;
        logic int_hiz;
        logic motion_armed;
        logic stillness_armed;
    } state_t;

    localparam state_t STATE_RESET = '{
        x: '0, y: '0, z: '0, t: '0, count: '0,
        err: 1'b1, awake: 1'b1, still: 1'b0, motion: 1'b0,
        overrun: 1'b0, mark: 1'b0, ready: 1'b0, data_ready: 1'b0,
        rdata: ZERO_BYTE, soft_reset: 1'b0, int_hiz: 1'b1,
        motion_armed: 1'b1, stillness_armed: 1'b1
    };

    // upper byte of a sign-extended pair
    function automatic logic [DATA_W-1:0] high_byte(input logic [SAMPLE_W-1:0] s);
        high_byte = {{4{s[SAMPLE_W-1]}}, s[SAMPLE_W-1:DATA_W]}; // [R15] [R14]
    endfunction

    // single-byte reduced resolution view
    function automatic logic [DATA_W-1:0] top_byte(input logic [SAMPLE_W-1:0] s);
        top_byte = s[SAMPLE_W-1:SAMPLE_W-DATA_W];
    endfunction

    state_t state_reg;
    state_t state_next;
    logic linked;
    logic loop_mode;
    logic flags_read;
    logic restart_hit;
    logic [COUNT_W-1:0] count_clip;
    logic [DATA_W-1:0] flags;

    always_comb
    begin
        state_next = state_reg;
        linked = (motion_detect_control_i == MODE_LINKED) || (motion_detect_control_i == MODE_LOOP);
        loop_mode = (motion_detect_control_i == MODE_LOOP);
        flags_read = reg_rd_i && (reg_addr_i == DEVICE_CONDITION_FLAGS_ADDR);
        restart_hit = reg_wr_i && (reg_addr_i == SOFTWARE_RESTART_ADDR) && (reg_wdata_i == RESTART_CODE);
        count_clip = (buffer_count_i > COUNT_MAX) ? COUNT_MAX : buffer_count_i; // [R12]
        flags = ZERO_BYTE;
        flags[ERR_BIT] = state_reg.err;
        flags[AWAKE_BIT] = state_reg.awake;
        flags[STILL_BIT] = state_reg.still;
        flags[MOTION_BIT] = state_reg.motion;
        flags[OVERRUN_BIT] = state_reg.overrun;
        flags[MARK_BIT] = state_reg.mark;
        flags[READY_BIT] = state_reg.ready;
        flags[DATA_READY_BIT] = state_reg.data_ready;

        state_next.soft_reset = 1'b0;
        if (sample_valid_i)
        begin
            state_next.x = x_sample_i;
            state_next.y = y_sample_i;
            state_next.z = z_sample_i;
            state_next.t = thermal_sample_i; // [R16]
        end
        state_next.count = count_clip;
        state_next.mark = ({1'b0, buffer_mark_i} <= count_clip); // [R8]
        state_next.ready = (count_clip != '0); // [R9]

        // register writes clear the error flag and release the interrupt pins
        if (reg_wr_i)
        begin
            state_next.err = 1'b0; // [R2]
            state_next.int_hiz = 1'b0;
        end
        if (single_event_upset_i)
            state_next.err = 1'b1; // [R3]

        // status read acknowledges the sticky flags; a same-cycle event wins
        if (flags_read)
        begin
            state_next.still = 1'b0;
            state_next.motion = 1'b0;
            state_next.overrun = 1'b0;
        end
        if (buffer_read_i)
            state_next.data_ready = 1'b0;
        if (sample_valid_i)
            state_next.data_ready = 1'b1; // [R10]
        if (buffer_overrun_i)
            state_next.overrun = 1'b1; // [R7]

        if (linked)
        begin
            // only one detector runs; the awake state picks which one [R21]
            if (state_reg.awake && stillness_event_i)
            begin
                state_next.awake = 1'b0; // [R4]
                state_next.still = 1'b1; // [R5]
                if (loop_mode)
                    state_next.motion = 1'b0; // [R21]
            end
            if (!state_reg.awake && motion_event_i)
            begin
                state_next.awake = 1'b1; // [R4]
                state_next.motion = 1'b1; // [R6]
                if (loop_mode)
                    state_next.still = 1'b0; // [R21]
            end
            state_next.motion_armed = !state_next.awake;
            state_next.stillness_armed = state_next.awake;
        end
        else
        begin
            state_next.awake = 1'b1; // [R4]
            state_next.motion_armed = 1'b1;
            state_next.stillness_armed = 1'b1;
            if (stillness_event_i)
                state_next.still = 1'b1; // [R5]
            if (motion_event_i)
                state_next.motion = 1'b1; // [R6]
        end

        state_next.rdata = ZERO_BYTE;
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                X_AXIS_BYTE_ADDR: state_next.rdata = top_byte(state_reg.x); // [R20]
                Y_AXIS_BYTE_ADDR: state_next.rdata = top_byte(state_reg.y); // [R1]
                Z_AXIS_BYTE_ADDR: state_next.rdata = top_byte(state_reg.z); // [R1]
                DEVICE_CONDITION_FLAGS_ADDR: state_next.rdata = flags;
                BUFFER_COUNT_LOW_ADDR: state_next.rdata = state_reg.count[DATA_W-1:0]; // [R13]
                BUFFER_COUNT_HIGH_ADDR: state_next.rdata = {6'h0_0, state_reg.count[COUNT_W-1:DATA_W]}; // [R13]
                X_SAMPLE_LOW_ADDR: state_next.rdata = state_reg.x[DATA_W-1:0]; // [R14]
                X_SAMPLE_HIGH_ADDR: state_next.rdata = high_byte(state_reg.x);
                Y_SAMPLE_LOW_ADDR: state_next.rdata = state_reg.y[DATA_W-1:0]; // [R14]
                Y_SAMPLE_HIGH_ADDR: state_next.rdata = high_byte(state_reg.y);
                Z_SAMPLE_LOW_ADDR: state_next.rdata = state_reg.z[DATA_W-1:0]; // [R14]
                Z_SAMPLE_HIGH_ADDR: state_next.rdata = high_byte(state_reg.z);
                THERMAL_SAMPLE_LOW_ADDR: state_next.rdata = state_reg.t[DATA_W-1:0]; // [R16]
                THERMAL_SAMPLE_HIGH_ADDR: state_next.rdata = high_byte(state_reg.t); // [R16]
                SOFTWARE_RESTART_ADDR: state_next.rdata = ZERO_BYTE; // [R19]
                default: state_next.rdata = ZERO_BYTE;
            endcase
        end

        // other codes written to the restart register only count as a plain write [R22]
        if (restart_hit)
        begin
            state_next = STATE_RESET; // [R17] [R11] [R18]
            state_next.soft_reset = 1'b1; // [R17]
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            state_reg <= STATE_RESET; // [R11] [R2]
        else
            state_reg <= state_next;
    end

    assign reg_rdata_o = state_reg.rdata;
    assign soft_reset_o = state_reg.soft_reset;
    assign int_hiz_o = state_reg.int_hiz;
    assign motion_armed_o = state_reg.motion_armed;
    assign stillness_armed_o = state_reg.stillness_armed;
endmodule // accel_data_status_regs

// ===== design/accel_regs_pkg.sv
// constants for the data and status register bank of the motion sensor
// assumes a serial front end that turns host frames into register strobes on core_clk_i
// Behaviour
// R1: y and z single-byte registers carry upper eight bits of current sample.
// R2: error flag bit 7 set at power-up and soft reset, cleared by any write.
// R3: error flag also set when a register upset is reported.
// R4: bit 6 shows awake state; reads 1 unless linked or loop mode.
// R5: bit 5 set when inactivity or free fall is detected.
// R6: bit 4 set when activity over threshold is detected.
// R7: bit 3 set when buffer overflows and unread samples are replaced.
// R8: bit 2 high while buffer count reaches programmed sample count.
// R9: bit 1 high while at least one sample is in buffer output.
// R10: bit 0 set on new sample, cleared by a buffer read.
// R11: status register resets to 0x40, only awake high; the code resets it to 0xC0, with the error flag also high.
// R12: buffer count reported from 0 to 512 inclusive.
// R13: count low byte in low register, two upper bits in high register.
// R14: each 12-bit axis sample split low eight bits and upper four bits.
// R15: bits 15 to 12 of every pair copy bit 11.
// R16: temperature sample uses the same sign-extended pair layout.
// R17: writing 0x52 to soft reset register resets device to defaults and standby.
// R18: after soft reset interrupt outputs go high impedance.
// R19: soft reset register is write-only and reads 0x00.
// R20: x-axis single-byte register at 0x08 carries upper eight sample bits.
// R21: linked and loop modes alternate detectors; loop mode acknowledges internally.
// R22: soft reset register writes of other values have no effect; the code treats them as a plain register write.
package accel_regs_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int SAMPLE_W = 12;
    localparam int COUNT_W = 10;
    localparam int MARK_W = 9;

    localparam logic [ADDR_W-1:0] X_AXIS_BYTE_ADDR = 8'h08;
    localparam logic [ADDR_W-1:0] Y_AXIS_BYTE_ADDR = 8'h09;
    localparam logic [ADDR_W-1:0] Z_AXIS_BYTE_ADDR = 8'h0a;
    localparam logic [ADDR_W-1:0] DEVICE_CONDITION_FLAGS_ADDR = 8'h0b;
    localparam logic [ADDR_W-1:0] BUFFER_COUNT_LOW_ADDR = 8'h0c;
    localparam logic [ADDR_W-1:0] BUFFER_COUNT_HIGH_ADDR = 8'h0d;
    localparam logic [ADDR_W-1:0] X_SAMPLE_LOW_ADDR = 8'h0e;
    localparam logic [ADDR_W-1:0] X_SAMPLE_HIGH_ADDR = 8'h0f;
    localparam logic [ADDR_W-1:0] Y_SAMPLE_LOW_ADDR = 8'h10;
    localparam logic [ADDR_W-1:0] Y_SAMPLE_HIGH_ADDR = 8'h11;
    localparam logic [ADDR_W-1:0] Z_SAMPLE_LOW_ADDR = 8'h12;
    localparam logic [ADDR_W-1:0] Z_SAMPLE_HIGH_ADDR = 8'h13;
    localparam logic [ADDR_W-1:0] THERMAL_SAMPLE_LOW_ADDR = 8'h14;
    localparam logic [ADDR_W-1:0] THERMAL_SAMPLE_HIGH_ADDR = 8'h15;
    localparam logic [ADDR_W-1:0] SOFTWARE_RESTART_ADDR = 8'h1f;

    localparam logic [DATA_W-1:0] RESTART_CODE = 8'h52;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h40;

    localparam int ERR_BIT = 7;
    localparam int AWAKE_BIT = 6;
    localparam int STILL_BIT = 5;
    localparam int MOTION_BIT = 4;
    localparam int OVERRUN_BIT = 3;
    localparam int MARK_BIT = 2;
    localparam int READY_BIT = 1;
    localparam int DATA_READY_BIT = 0;

    localparam logic [COUNT_W-1:0] COUNT_MAX = 10'h200;

    // motion_detect_control link/loop field: x0 default, 01 linked, 11 loop
    localparam logic [1:0] MODE_LINKED = 2'h1;
    localparam logic [1:0] MODE_LOOP = 2'h3;
endpackage

// ===== tb/accel_regs_assertions.sv
// port checker for the data and status bank
// assumes strobes stay low while reset is held
`timescale 1ns/1ps
module accel_regs_assertions (
    input wire logic core_clk_i, resetn_i, reg_wr_i, reg_rd_i, single_event_upset_i, soft_reset_o, int_hiz_o,
    input wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
    input wire logic [9:0] buffer_count_i,
    input wire logic [8:0] buffer_mark_i,
    input wire logic [1:0] motion_detect_control_i
);
    import accel_regs_pkg::*;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    wire rs = reg_wr_i && reg_addr_i == SOFTWARE_RESTART_ADDR && reg_wdata_i == RESTART_CODE;
    wire sr = reg_rd_i && reg_addr_i == DEVICE_CONDITION_FLAGS_ADDR;
    a_restart_pulse: assert property (rs |=> soft_reset_o)
        else $error("no restart pulse");
    a_restart_only: assert property (soft_reset_o |-> $past(rs))
        else $error("stray restart");
    a_restart_hiz: assert property (soft_reset_o |-> int_hiz_o)
        else $error("pins driven after restart");
    a_restart_read: assert property (reg_rd_i && reg_addr_i == SOFTWARE_RESTART_ADDR |=> reg_rdata_o == 8'h00)
        else $error("restart register read nonzero");
    // read data stands for one cycle only, so a stale byte never reaches the front end
    a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data without a read strobe");
    a_count_range: assert property (reg_rd_i && reg_addr_i == BUFFER_COUNT_HIGH_ADDR |=> reg_rdata_o <= 8'h02)
        else $error("count above 512");
    a_awake_default: assert property (sr && !motion_detect_control_i[0]
        && !$past(motion_detect_control_i[0]) |=> reg_rdata_o[AWAKE_BIT]) else $error("awake low in default mode");
    // flags lag the count by one cycle, and a restart in between reloads them
    a_buffer_levels: assert property (sr && !soft_reset_o |=> reg_rdata_o[2:1] ==
        {$past(buffer_count_i, 2) >= $past(buffer_mark_i, 2), $past(buffer_count_i, 2) != 10'h000})
        else $error("buffer flags wrong");
    a_err_cleared: assert property (reg_wr_i && !rs && !single_event_upset_i ##1 !single_event_upset_i[*2] ##0 sr
        |=> !reg_rdata_o[ERR_BIT]) else $error("error flag kept after write");
    a_upset_err: assert property (single_event_upset_i ##1 !reg_wr_i ##1 sr |=> reg_rdata_o[ERR_BIT])
        else $error("upset not flagged");
endmodule // accel_regs_assertions
bind accel_data_status_regs accel_regs_assertions u_accel_regs_assertions (.core_clk_i, .resetn_i, .reg_wr_i,
    .reg_rd_i, .single_event_upset_i, .soft_reset_o, .int_hiz_o, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
    .buffer_count_i, .buffer_mark_i, .motion_detect_control_i);

// ===== tb/accel_host_model.sv
// host model: one-cycle read and write strobes
// assumes read data is valid the cycle after the strobe edge
`timescale 1ns/1ps
module accel_host_model (
    input wire logic core_clk_i,
    output logic reg_wr_o, reg_rd_o,
    output logic [7:0] reg_addr_o, reg_wdata_o,
    input wire logic [7:0] reg_rdata_i
);
    initial {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = '0;
    // released lines carry the inverse, never a held copy
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        {reg_rd_o, reg_addr_o} <= {1'b1, a};
        @(posedge core_clk_i);
        {reg_rd_o, reg_addr_o} <= {1'b0, ~a};
        #1 d = reg_rdata_i;
    endtask
    task automatic wr(input logic [7:0] a, v);
        @(posedge core_clk_i);
        {reg_wr_o, reg_addr_o, reg_wdata_o} <= {1'b1, a, v}; // restart code only when asked
        @(posedge core_clk_i);
        {reg_wr_o, reg_addr_o, reg_wdata_o} <= {1'b0, ~a, ~v};
    endtask
endmodule // accel_host_model

// ===== tb/accel_data_status_regs_tb_top.sv
// bench: host model on the strobes, samples and events driven here
// assumes a single clock domain
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; $display("unexpected %0t: %h", $time, g); end end
module accel_data_status_regs_tb_top;
    import accel_regs_pkg::*;
    logic core_clk_i, resetn_i, soft_reset_o, int_hiz_o, motion_armed_o, stillness_armed_o, reg_wr_i, reg_rd_i;
    logic sample_valid_i, buffer_overrun_i, buffer_read_i, motion_event_i, stillness_event_i, single_event_upset_i;
    logic err, awk, st, mo, ov, dr;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic [11:0] x_sample_i, y_sample_i, z_sample_i, thermal_sample_i, xs, ys, zs, ts;
    logic [9:0] buffer_count_i, cn;
    logic [8:0] buffer_mark_i;
    logic [1:0] motion_detect_control_i;
    logic [5:0] evs;
    int n_mismatch, num_checks;
    assign {single_event_upset_i, sample_valid_i, buffer_overrun_i} = evs[5:3];
    assign {motion_event_i, stillness_event_i, buffer_read_i} = evs[2:0];
    accel_data_status_regs u_accel_data_status_regs (.*);
    accel_host_model u_accel_host_model (.core_clk_i, .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
        .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o));
    function automatic logic [7:0] exp_reg(input logic [7:0] a);
        logic [11:0] s;
        s = a < 8'h10 ? xs : a < 8'h12 ? ys : a < 8'h14 ? zs : ts;
        case (a)
            8'h08, 8'h09, 8'h0a: return a[1] ? zs[11:4] : a[0] ? ys[11:4] : xs[11:4];
            8'h0b: return {err, awk, st, mo, ov, cn >= buffer_mark_i, cn != 10'h000, dr};
            8'h0c: return cn[7:0];
            8'h0d: return {6'h00, cn[9:8]};
            default: return a > 8'h15 ? 8'h00 : a[0] ? {{4{s[11]}}, s[11:8]} : s[7:0];
        endcase
    endfunction
    task automatic chk(input logic [7:0] a);
        logic [7:0] d;
        u_accel_host_model.rd(a, d);
        `CHK(d, exp_reg(a))
        if (a == DEVICE_CONDITION_FLAGS_ADDR) {st, mo, ov} = 3'b000;
    endtask
    task automatic ev(input logic [5:0] m);
        @(posedge core_clk_i);
        evs <= m;
        @(posedge core_clk_i);
        evs <= 6'h00;
        err |= m[5];
        {ov, mo, st} = {ov, mo, st} | m[3:1];
        dr = m[4] | (dr & !m[0]);
        if (m[4]) {xs, ys, zs, ts} = {x_sample_i, y_sample_i, z_sample_i, thermal_sample_i};
    endtask
    task automatic dflt();
        {err, awk, st, mo, ov, dr, xs, ys, zs, ts} = {2'b11, 52'h0};
    endtask
    task automatic wr(input logic [7:0] a, v);
        u_accel_host_model.wr(a, v);
        #1;
        err = 0;
        if (a == SOFTWARE_RESTART_ADDR && v == RESTART_CODE) dflt();
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        core_clk_i = 0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    initial begin
        #(4 * 8000);
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        {resetn_i, evs, motion_detect_control_i, buffer_count_i, cn} = '0;
        {x_sample_i, y_sample_i, z_sample_i, thermal_sample_i} = '0;
        buffer_mark_i = 9'h001;
        dflt();
        void'($urandom(32'hc8479d43));
        repeat (5) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        for (int a = 8; a < 32; a++) chk(8'(a));
        for (int i = 0; i < 40; i++)
        begin
            @(posedge core_clk_i);
            {x_sample_i, y_sample_i, z_sample_i, thermal_sample_i} <=
                i < 2 ? {4{(i ? 12'h7ff : 12'h800)}} : 48'({$urandom, $urandom});
            buffer_count_i <= i == 2 ? COUNT_MAX : 10'($urandom);
            buffer_mark_i <= 9'($urandom_range(1, 511));
            ev({2'b01, 3'($urandom), i[1]});
            if (i[2]) ev(6'h01);
            @(posedge core_clk_i);
            // inputs move on; the latched copy must not
            {x_sample_i, y_sample_i, z_sample_i, thermal_sample_i} <= 48'({$urandom, $urandom});
            cn = buffer_count_i > COUNT_MAX ? COUNT_MAX : buffer_count_i;
            for (int a = 8; a < 22; a++) chk(8'(a));
        end
        wr(DEVICE_CONDITION_FLAGS_ADDR, 8'h5a);
        `CHK(int_hiz_o, 1'b0)
        chk(DEVICE_CONDITION_FLAGS_ADDR);
        wr(SOFTWARE_RESTART_ADDR, 8'h53);
        chk(X_SAMPLE_LOW_ADDR);
        ev(6'h20);
        chk(DEVICE_CONDITION_FLAGS_ADDR);
        wr(SOFTWARE_RESTART_ADDR, RESTART_CODE);
        `CHK(int_hiz_o, 1'b1)
        for (int a = 8; a < 22; a++) chk(8'(a));
        @(posedge core_clk_i);
        motion_detect_control_i <= MODE_LINKED;
        ev(6'h02);
        awk = 0;
        repeat (2) @(negedge core_clk_i);
        `CHK({motion_armed_o, stillness_armed_o}, 2'b10)
        @(posedge core_clk_i);
        motion_detect_control_i <= MODE_LOOP;
        ev(6'h04);
        {awk, st} = 2'b10;
        repeat (2) @(negedge core_clk_i);
        `CHK({motion_armed_o, stillness_armed_o}, 2'b01)
        chk(DEVICE_CONDITION_FLAGS_ADDR);
        // back to default mode with the high field bit set: both detectors armed again
        @(posedge core_clk_i);
        motion_detect_control_i <= 2'b10;
        repeat (2) @(negedge core_clk_i);
        `CHK({motion_armed_o, stillness_armed_o}, 2'b11)
        chk(DEVICE_CONDITION_FLAGS_ADDR);
        tally_and_finish();
    end
endmodule // accel_data_status_regs_tb_top
